/* File: design/snlc_consts.svh */
// How it works
// - cycle code 0,1,3,6 give 0.0833, 0.1666, 0.5, 1.0 ms; others reserved.
// - shortest cycle selected turns pulse regeneration output off.
// - command update is cycle times 1 or 2; 2 only with 0.0833 or 0.5 ms.
// - setup word A bit 0 picks 16-byte (0) or 32-byte (1) frames.
// - setup word A bit 1 picks semi (0) or full (1) axis synchronisation.
// - setup word B bit 0 set refuses parameter writes from the network.
// - setup word B bit 1 clear forces alarm sub-number to zero.
// - limit function off and word B bit 2 set force hardware limit bits zero.
// - word B bit 3 clear: positive limit bit 1, negative bit 0; set swaps.
// - word B bit 4 selects indicator LED mode 1 or mode 2.
// - word B bit 5 picks what change starts a non-cyclic command.
// - word B bits 6 and 7 invert hardware and soft limit bits.
// - word B bit 8 picks in-progress (0) or mains-loss warning (1).
// - word B bit 9 set returns command error toward inhibited direction.
// - word C bits 0,1 pick hold or initialise outputs after link loss.
// - speed unit 0 is mm/s, 1 is command units per second.
// - consecutive error count reaching threshold warns; zero disables.
// - total error count reaching threshold warns; zero disables.
// - refresh failures beyond threshold warn; zero or one disables.
// - slot one carries programmed monitor code; zero gives actual position.
// - with non-cyclic command zero, slots two, three carry programmed items.
// - 32-byte mode sub slots carry programmed items, the first only with sub command zero; zero returns zero.
`ifndef SNLC_CONSTS_SVH
`define SNLC_CONSTS_SVH
`define SNLC_IDX_FIRST 6'h14
`define SNLC_IDX_LAST 6'h22
`define SNLC_NREG 15
`define SNLC_R_CYCLE 0
`define SNLC_R_RATIO 1
`define SNLC_R_SETA 2
`define SNLC_R_SETB 3
`define SNLC_R_SETC 4
`define SNLC_R_SPEED 5
`define SNLC_R_THR_CONS 6
`define SNLC_R_THR_TOT 7
`define SNLC_R_THR_REF 8
`define SNLC_R_MON1 9
`define SNLC_RST_CYCLE 16'h0003
`define SNLC_RST_RATIO 16'h0001
`define SNLC_A_FRAME32 0
`define SNLC_A_FULLSYNC 1
`define SNLC_B_NOWRITE 0
`define SNLC_B_ALMSUB 1
`define SNLC_B_LIMZERO 2
`define SNLC_B_LIMSWAP 3
`define SNLC_B_LED2 4
`define SNLC_B_NCMODE 5
`define SNLC_B_HWINV 6
`define SNLC_B_SWINV 7
`define SNLC_B_SHARED 8
`define SNLC_B_CMDERR 9
`define SNLC_C_INIT1 0
`define SNLC_C_INIT2 1
`define SNLC_CYC0_NS 20'd83300
`define SNLC_CYC1_NS 20'd166600
`define SNLC_CYC3_NS 20'd500000
`define SNLC_CYC6_NS 20'd1000000
`endif

/* File: design/snlc_pkg.sv */
package snlc_pkg;
  // one word handed to the frame transmitter
  typedef struct packed {
    logic [2:0]  slot;
    logic [7:0]  code;
    logic [31:0] data;
  } snlc_reply_t;
  // shaped status bits
  typedef struct packed {
    logic [1:0] hw_limit;
    logic [1:0] soft_limit;
    logic       shared_bit;
    logic [7:0] alarm_sub;
  } snlc_status_t;
  // latched warnings
  typedef struct packed {
    logic consecutive_error_warning;
    logic total_error_warning;
    logic refresh_fault_warning;
  } snlc_warn_t;
  typedef enum logic [1:0] {
    SNLC_IDLE = 2'b00,
    SNLC_EMIT = 2'b01
  } snlc_gen_t;
endpackage

/* File: design/snlc_top.sv */
`timescale 1ns/1ns
`include "snlc_consts.svh"
module snlc_top
  import snlc_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         param_wr_in,
  input  wire logic         param_rd_in,
  input  wire logic         param_net_in,
  input  wire logic [5:0]   param_index_in,
  input  wire logic [15:0]  param_wdata_in,
  output logic [15:0]       param_rdata_out,
  output logic              param_ack_out,
  output logic              param_refused_out,
  output logic [19:0]       link_cycle_ns_out,
  output logic              cmd_ratio2_out,
  output logic              config_error_out,
  output logic              pulse_regen_en_out,
  output logic              frame_32_out,
  output logic              full_sync_out,
  output logic              speed_unit_out,
  input  wire logic         positive_travel_limit_in,
  input  wire logic         negative_travel_limit_in,
  input  wire logic         positive_soft_limit_in,
  input  wire logic         negative_soft_limit_in,
  input  wire logic         travel_func_off_in,
  input  wire logic         in_progress_in,
  input  wire logic         mains_loss_warning_flag_in,
  input  wire logic [7:0]   alarm_sub_in,
  output snlc_status_t      status_out,
  input  wire logic         travel_stopped_in,
  input  wire logic         cmd_toward_inhibit_in,
  output logic              cmd_error_out,
  input  wire logic         frame_start_in,
  input  wire logic [15:0]  std_cmd_in,
  input  wire logic [7:0]   cmd_code_in,
  input  wire logic [15:0]  cmd_param_in,
  output logic              noncyclic_start_out,
  input  wire logic         link_up_in,
  input  wire logic         external_output_one_in,
  input  wire logic         external_output_two_in,
  output logic              external_output_one_out,
  output logic              external_output_two_out,
  output logic              link_indicator_led_out,
  input  wire logic         comm_error_in,
  input  wire logic         comm_good_in,
  input  wire logic         refresh_fault_in,
  input  wire logic         warn_clear_in,
  output snlc_warn_t        warn_out,
  input  wire logic         noncyclic_zero_in,
  input  wire logic         sub_cmd_zero_in,
  input  wire logic [31:0]  actual_position_in,
  input  wire logic [31:0]  actual_speed_in,
  input  wire logic [31:0]  thrust_value_in,
  input  wire logic         reply_ready_in,
  output logic              reply_valid_out,
  output snlc_reply_t       reply_word_out
);

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic logic [15:0] rst_val(input int i);
    if (i == `SNLC_R_CYCLE) return `SNLC_RST_CYCLE;
    if (i == `SNLC_R_RATIO) return `SNLC_RST_RATIO;
    return 16'h0000;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // code to period; reserved codes report zero
  function automatic logic [19:0] cycle_ns(input logic [15:0] c);
    case (c)
      16'h0000: cycle_ns = `SNLC_CYC0_NS;
      16'h0001: cycle_ns = `SNLC_CYC1_NS;
      16'h0003: cycle_ns = `SNLC_CYC3_NS;
      16'h0006: cycle_ns = `SNLC_CYC6_NS;
      default:  cycle_ns = 20'h00000;
    endcase
  endfunction

  // parameter store, indexed by printed number minus the first
  logic [15:0] cfg_q [0:`SNLC_NREG-1];
  logic        idx_ok;
  logic [3:0]  idx;
  logic        net_block;
  assign idx_ok = (param_index_in >= `SNLC_IDX_FIRST) && (param_index_in <= `SNLC_IDX_LAST);
  assign idx = 4'(param_index_in - `SNLC_IDX_FIRST);
  assign net_block = param_net_in & cfg_q[`SNLC_R_SETB][`SNLC_B_NOWRITE];

  // writes from the network are dropped while locked out
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < `SNLC_NREG; i++) begin
        cfg_q[i] <= rst_val(i);
      end
    end else if (param_wr_in && idx_ok && !net_block) begin
      cfg_q[idx] <= param_wdata_in;
    end
  end

  // read data, acknowledge and refusal pulses
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      param_rdata_out   <= 16'h0000;
      param_ack_out     <= 1'b0;
      param_refused_out <= 1'b0;
    end else begin
      param_ack_out     <= param_wr_in | param_rd_in;
      param_refused_out <= param_wr_in & net_block;
      if (param_rd_in) begin
        param_rdata_out <= idx_ok ? cfg_q[idx] : 16'h0000;
      end
    end
  end

  logic [15:0] cyc;
  logic [15:0] seta;
  logic [15:0] setb;
  logic [15:0] setc;
  logic        short_cycle;
  assign cyc  = cfg_q[`SNLC_R_CYCLE];
  assign seta = cfg_q[`SNLC_R_SETA];
  assign setb = cfg_q[`SNLC_R_SETB];
  assign setc = cfg_q[`SNLC_R_SETC];
  assign short_cycle = (cyc == 16'h0000);

  // link configuration; bad combinations are flagged, not corrected
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      link_cycle_ns_out  <= 20'h00000;
      cmd_ratio2_out     <= 1'b0;
      config_error_out   <= 1'b0;
      pulse_regen_en_out <= 1'b0;
      frame_32_out       <= 1'b0;
      full_sync_out      <= 1'b0;
      speed_unit_out     <= 1'b0;
    end else begin
      link_cycle_ns_out  <= cycle_ns(cyc);
      cmd_ratio2_out     <= (cfg_q[`SNLC_R_RATIO] == 16'h0002);
      config_error_out   <= (cycle_ns(cyc) == 20'h00000)
        || !(cfg_q[`SNLC_R_RATIO] inside {16'h0001, 16'h0002})
        || ((cfg_q[`SNLC_R_RATIO] == 16'h0002) && !(short_cycle || cyc == 16'h0003));
      pulse_regen_en_out <= !short_cycle;
      frame_32_out       <= seta[`SNLC_A_FRAME32];
      full_sync_out      <= seta[`SNLC_A_FULLSYNC];
      speed_unit_out     <= cfg_q[`SNLC_R_SPEED][0];
    end
  end

  // status shaping: invert, then force, then place
  logic hw_pos;
  logic hw_neg;
  logic lim_zero;
  assign hw_pos = positive_travel_limit_in ^ setb[`SNLC_B_HWINV];
  assign hw_neg = negative_travel_limit_in ^ setb[`SNLC_B_HWINV];
  assign lim_zero = travel_func_off_in & setb[`SNLC_B_LIMZERO];
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_out    <= '0;
      cmd_error_out <= 1'b0;
    end else begin
      if (lim_zero) begin
        status_out.hw_limit <= 2'b00;
      end else if (setb[`SNLC_B_LIMSWAP]) begin
        status_out.hw_limit <= {hw_neg, hw_pos};
      end else begin
        status_out.hw_limit <= {hw_pos, hw_neg};
      end
      status_out.soft_limit <= {positive_soft_limit_in, negative_soft_limit_in}
        ^ {2{setb[`SNLC_B_SWINV]}};
      status_out.shared_bit <= setb[`SNLC_B_SHARED] ? mains_loss_warning_flag_in
                                                    : in_progress_in;
      status_out.alarm_sub  <= setb[`SNLC_B_ALMSUB] ? alarm_sub_in : 8'h00;
      cmd_error_out <= setb[`SNLC_B_CMDERR] & travel_stopped_in
                       & cmd_toward_inhibit_in;
    end
  end

  // non-cyclic start detection, sampled once per frame
  logic [15:0] prev_std_q;
  logic [7:0]  prev_code_q;
  logic [15:0] prev_param_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prev_std_q          <= 16'h0000;
      prev_code_q         <= 8'h00;
      prev_param_q        <= 16'h0000;
      noncyclic_start_out <= 1'b0;
    end else begin
      noncyclic_start_out <= 1'b0;
      if (frame_start_in) begin
        prev_std_q   <= std_cmd_in;
        prev_code_q  <= cmd_code_in;
        prev_param_q <= cmd_param_in;
        if (setb[`SNLC_B_NCMODE]) begin
          noncyclic_start_out <= (cmd_code_in != prev_code_q)
                                 || (cmd_param_in != prev_param_q);
        end else begin
          noncyclic_start_out <= (std_cmd_in != prev_std_q);
        end
      end
    end
  end

  // external outputs: before the link first comes up they stay initialised
  logic was_up_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      was_up_q                <= 1'b0;
      external_output_one_out <= 1'b0;
      external_output_two_out <= 1'b0;
    end else if (link_up_in) begin
      was_up_q                <= 1'b1;
      external_output_one_out <= external_output_one_in;
      external_output_two_out <= external_output_two_in;
    end else if (was_up_q) begin
      if (setc[`SNLC_C_INIT1]) begin
        external_output_one_out <= 1'b0;
      end
      if (setc[`SNLC_C_INIT2]) begin
        external_output_two_out <= 1'b0;
      end
    end
  end

  // error counters saturate so a long outage cannot wrap to quiet
  logic [15:0] cons_q;
  logic [15:0] tot_q;
  logic [15:0] ref_q;
  logic [15:0] cons_d;
  logic [15:0] tot_d;
  logic [15:0] ref_d;
  logic [15:0] thr_c;
  logic [15:0] thr_t;
  logic [15:0] thr_r;
  assign thr_c = cfg_q[`SNLC_R_THR_CONS];
  assign thr_t = cfg_q[`SNLC_R_THR_TOT];
  assign thr_r = cfg_q[`SNLC_R_THR_REF];
  always_comb begin
    cons_d = warn_clear_in ? 16'h0000 : cons_q;
    tot_d  = warn_clear_in ? 16'h0000 : tot_q;
    ref_d  = warn_clear_in ? 16'h0000 : ref_q;
    if (comm_error_in) begin
      cons_d = sat_inc(cons_d);
      tot_d  = sat_inc(tot_d);
    end else if (comm_good_in) begin
      cons_d = 16'h0000;
    end
    if (refresh_fault_in) begin
      ref_d = sat_inc(ref_d);
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cons_q <= 16'h0000;
      tot_q  <= 16'h0000;
      ref_q  <= 16'h0000;
    end else begin
      cons_q <= cons_d;
      tot_q  <= tot_d;
      ref_q  <= ref_d;
    end
  end

  // warning flags; counts restart from zero on clear, so a hit in the clearing cycle keeps an error flag only at a threshold of 1 and never the refresh flag
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      warn_out <= '0;
    end else begin
      warn_out.consecutive_error_warning <= (warn_out.consecutive_error_warning & ~warn_clear_in)
        | ((thr_c != 16'h0000) && (cons_d >= thr_c));
      warn_out.total_error_warning <= (warn_out.total_error_warning & ~warn_clear_in)
        | ((thr_t != 16'h0000) && (tot_d >= thr_t));
      warn_out.refresh_fault_warning <= (warn_out.refresh_fault_warning & ~warn_clear_in)
        | ((thr_r > 16'h0001) && (ref_d > thr_r));
    end
  end

  // indicator: mode 2 also goes dark while any warning is latched
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      link_indicator_led_out <= 1'b0;
    end else begin
      link_indicator_led_out <= link_up_in
        & ~(setb[`SNLC_B_LED2] & (|warn_out));
    end
  end

  // two-entry skid buffer toward the transmitter
  snlc_reply_t skid_q;
  logic        skid_v_q;
  logic        buf_ready;
  logic        push;
  snlc_reply_t push_word;
  assign buf_ready = ~skid_v_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reply_valid_out <= 1'b0;
      reply_word_out  <= '0;
      skid_q          <= '0;
      skid_v_q        <= 1'b0;
    end else if (!reply_valid_out || reply_ready_in) begin
      if (skid_v_q) begin
        reply_word_out  <= skid_q;
        reply_valid_out <= 1'b1;
        skid_v_q        <= 1'b0;
      end else begin
        reply_word_out  <= push_word;
        reply_valid_out <= push;
      end
    end else if (push) begin
      skid_q   <= push_word;
      skid_v_q <= 1'b1;
    end
  end

  // slot generator: walks slots 1..3, then 4..6 in 32-byte mode
  snlc_gen_t   gen_q;
  logic [2:0]  slot_q;
  logic        nc0_q;
  logic        sub0_q;
  logic        f32_q;
  logic        slot_on;
  logic        last_slot;
  logic [7:0]  code;
  always_comb begin
    code = cfg_q[`SNLC_R_MON1 + 32'(slot_q) - 1][7:0];
    case (slot_q)
      3'd2, 3'd3: slot_on = nc0_q;
      3'd4:       slot_on = sub0_q;
      default:    slot_on = 1'b1;
    endcase
    last_slot = f32_q ? (slot_q == 3'd6) : (slot_q == 3'd3);
    push_word.slot = slot_q;
    push_word.code = code;
    push_word.data = 32'h00000000;
    if (code == 8'h00) begin
      case (slot_q)
        3'd1:    push_word.data = actual_position_in;
        3'd2:    push_word.data = actual_speed_in;
        3'd3:    push_word.data = thrust_value_in;
        default: push_word.data = 32'h00000000;
      endcase
    end
  end
  assign push = (gen_q == SNLC_EMIT) && slot_on && buf_ready;

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gen_q  <= SNLC_IDLE;
      slot_q <= 3'd1;
      nc0_q  <= 1'b0;
      sub0_q <= 1'b0;
      f32_q  <= 1'b0;
    end else begin
      case (gen_q)
        SNLC_IDLE: begin
          if (frame_start_in) begin
            gen_q  <= SNLC_EMIT;
            slot_q <= 3'd1;
            nc0_q  <= noncyclic_zero_in;
            sub0_q <= sub_cmd_zero_in;
            f32_q  <= seta[`SNLC_A_FRAME32];
          end
        end
        SNLC_EMIT: begin
          if (!slot_on || buf_ready) begin
            if (last_slot) begin
              gen_q <= SNLC_IDLE;
            end else begin
              slot_q <= slot_q + 3'd1;
            end
          end
        end
        default: gen_q <= SNLC_IDLE;
      endcase
    end
  end

  property p_regen;
    @(posedge clk_in) disable iff (!rst_n_q)
      short_cycle |=> !pulse_regen_en_out;
  endproperty
  a_regen: assert property (p_regen) else $error("regen on at short cycle");

  property p_ratio;
    @(posedge clk_in) disable iff (!rst_n_q)
      (cfg_q[`SNLC_R_RATIO] == 16'h0002 && cyc == 16'h0001) |=> config_error_out;
  endproperty
  a_ratio: assert property (p_ratio) else $error("bad ratio not flagged");

  property p_refuse;
    @(posedge clk_in) disable iff (!rst_n_q)
      (param_wr_in && net_block && idx_ok) |=> param_refused_out && $stable(cfg_q[idx]);
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked write taken");

  property p_almsub;
    @(posedge clk_in) disable iff (!rst_n_q)
      !setb[`SNLC_B_ALMSUB] |=> status_out.alarm_sub == 8'h00;
  endproperty
  a_almsub: assert property (p_almsub) else $error("alarm sub not zero");

  property p_limzero;
    @(posedge clk_in) disable iff (!rst_n_q)
      lim_zero |=> status_out.hw_limit == 2'b00;
  endproperty
  a_limzero: assert property (p_limzero) else $error("limit bits not forced");

  property p_place;
    @(posedge clk_in) disable iff (!rst_n_q)
      (!lim_zero && !setb[`SNLC_B_LIMSWAP] && !setb[`SNLC_B_HWINV])
      |=> status_out.hw_limit == {$past(positive_travel_limit_in),
                                  $past(negative_travel_limit_in)};
  endproperty
  a_place: assert property (p_place) else $error("limit placement wrong");

  property p_shared;
    @(posedge clk_in) disable iff (!rst_n_q)
      setb[`SNLC_B_SHARED] |=> status_out.shared_bit == $past(mains_loss_warning_flag_in);
  endproperty
  a_shared: assert property (p_shared) else $error("shared bit source wrong");

  property p_extinit;
    @(posedge clk_in) disable iff (!rst_n_q)
      (was_up_q && !link_up_in && setc[`SNLC_C_INIT1]) |=> !external_output_one_out;
  endproperty
  a_extinit: assert property (p_extinit) else $error("output one not initialised");

  property p_consoff;
    @(posedge clk_in) disable iff (!rst_n_q)
      (thr_c == 16'h0000 && (!warn_out.consecutive_error_warning || warn_clear_in))
      |=> !warn_out.consecutive_error_warning;
  endproperty
  a_consoff: assert property (p_consoff) else $error("disabled warning raised");

  property p_refoff;
    @(posedge clk_in) disable iff (!rst_n_q)
      (thr_r == 16'h0001 && !warn_out.refresh_fault_warning) |=> !warn_out.refresh_fault_warning;
  endproperty
  a_refoff: assert property (p_refoff) else $error("refresh warning at one");

  property p_latch;
    @(posedge clk_in) disable iff (!rst_n_q)
      (warn_out.total_error_warning && !warn_clear_in) |=> warn_out.total_error_warning;
  endproperty
  a_latch: assert property (p_latch) else $error("warning dropped uncleared");

  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_q)
      (reply_valid_out && !reply_ready_in) |=> reply_valid_out && $stable(reply_word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");

endmodule

/* File: sim/snlc_host_model.sv */
`timescale 1ns/1ns
module snlc_host_model
  import snlc_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         stall_in,
  input  wire logic         reply_valid_in,
  input  wire snlc_reply_t  reply_word_in,
  output logic              reply_ready_out
);
  snlc_reply_t got [8];
  int          cnt = 0;
  logic        phase = 1'b0;
  initial reply_ready_out = 1'b0;
  // ready drops every other cycle while stalling, so the skid buffer must carry words over
  always @(posedge clk_in) begin
    phase <= ~phase;
    reply_ready_out <= ~stall_in | phase;
    if (reply_valid_in && reply_ready_out) begin
      got[cnt[2:0]] <= reply_word_in;
      cnt <= cnt + 1;
    end
  end
endmodule

/* File: sim/snlc_top_tb.sv */
`timescale 1ns/1ns
module snlc_top_tb
  import snlc_pkg::*;
;
  logic clk_in, reset_n_in, param_wr_in, param_rd_in, param_net_in, param_ack_out;
  logic param_refused_out, cmd_ratio2_out, config_error_out, pulse_regen_en_out;
  logic frame_32_out, full_sync_out, speed_unit_out, travel_func_off_in, in_progress_in;
  logic positive_travel_limit_in, negative_travel_limit_in, positive_soft_limit_in;
  logic negative_soft_limit_in, mains_loss_warning_flag_in, travel_stopped_in;
  logic cmd_toward_inhibit_in, cmd_error_out, frame_start_in, noncyclic_start_out, link_up_in;
  logic external_output_one_in, external_output_two_in, external_output_one_out;
  logic external_output_two_out, link_indicator_led_out, comm_error_in, comm_good_in;
  logic refresh_fault_in, warn_clear_in, noncyclic_zero_in, sub_cmd_zero_in;
  logic reply_ready_in, reply_valid_out, stall, refused;
  logic [5:0] param_index_in;
  logic [7:0] alarm_sub_in, cmd_code_in;
  logic [15:0] param_wdata_in, param_rdata_out, std_cmd_in, cmd_param_in, rdata;
  logic [19:0] link_cycle_ns_out;
  logic [31:0] actual_position_in, actual_speed_in, thrust_value_in;
  snlc_status_t status_out;
  snlc_warn_t warn_out;
  snlc_reply_t reply_word_out;
  int errors = 0, checked = 0, cycles = 0, i;
  // last entry is a reserved code; 1 ms needs 20 bits
  const logic [15:0] cyc_code [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0006, 16'h0002};
  const logic [19:0] cyc_ns [5] = '{20'h14564, 20'h28AC8, 20'h7A120, 20'hF4240, 20'h00000};

  snlc_top uut (.*);
  snlc_host_model host (.clk_in(clk_in), .stall_in(stall), .reply_valid_in(reply_valid_out),
    .reply_word_in(reply_word_out), .reply_ready_out(reply_ready_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one strobe, then wait a bounded time for the acknowledge
  task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] d,
                     input logic net);
    int n;
    @(posedge clk_in);
    param_wr_in <= w;
    param_rd_in <= ~w;
    param_index_in <= idx;
    param_wdata_in <= d;
    param_net_in <= net;
    @(posedge clk_in);
    param_wr_in <= 1'b0;
    param_rd_in <= 1'b0;
    #1;
    for (n = 0; n < 4 && param_ack_out !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    refused = param_refused_out;
    rdata = param_rdata_out;
    chk("ack", param_ack_out, 1'b1);
  endtask

  // register and status outputs follow one cycle late
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  initial begin
    {reset_n_in, param_wr_in, param_rd_in, param_net_in, param_index_in, param_wdata_in} = '0;
    {positive_travel_limit_in, negative_travel_limit_in, positive_soft_limit_in} = '0;
    {negative_soft_limit_in, travel_func_off_in, in_progress_in, alarm_sub_in} = '0;
    {mains_loss_warning_flag_in, travel_stopped_in, cmd_toward_inhibit_in, frame_start_in} = '0;
    {std_cmd_in, cmd_code_in, cmd_param_in, link_up_in, external_output_one_in} = '0;
    {external_output_two_in, comm_error_in, comm_good_in, refresh_fault_in} = '0;
    {warn_clear_in, noncyclic_zero_in, sub_cmd_zero_in, stall} = '0;
    {actual_position_in, actual_speed_in, thrust_value_in} = '0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    bus(1'b0, 6'h14, 16'h0000, 1'b0);
    chk("cycle reg", rdata, 16'h0003);
    bus(1'b0, 6'h15, 16'h0000, 1'b0);
    chk("ratio reg", rdata, 16'h0001);
    chk("cycle ns", link_cycle_ns_out, 20'h7A120);
    $display("test reset done");
    // each defined cycle code and reserved code 2, each with ratio 2 and then ratio 1
    for (i = 0; i < 5; i++) begin
      bus(1'b1, 6'h14, cyc_code[i], 1'b0);
      bus(1'b1, 6'h15, 16'h0002, 1'b0);
      settle();
      chk("cycle ns", link_cycle_ns_out, cyc_ns[i]);
      chk("regen", pulse_regen_en_out, i != 0);
      chk("ratio2", cmd_ratio2_out, 1'b1);
      chk("cfg err r2", config_error_out, i != 0 && i != 2);
      bus(1'b1, 6'h15, 16'h0001, 1'b0);
      settle();
      chk("cfg err r1", config_error_out, i == 4);
    end
    bus(1'b1, 6'h14, 16'h0003, 1'b0);
    bus(1'b1, 6'h16, 16'h0003, 1'b0);
    bus(1'b1, 6'h19, 16'h0001, 1'b0);
    settle();
    chk("frame32", frame_32_out, 1'b1);
    chk("full sync", full_sync_out, 1'b1);
    chk("speed unit", speed_unit_out, 1'b1);
    bus(1'b1, 6'h16, 16'h0000, 1'b0);
    settle();
    chk("frame16", frame_32_out, 1'b0);
    $display("test config done");
    // network writes locked out, local writes still land
    bus(1'b1, 6'h17, 16'h0001, 1'b0);
    bus(1'b1, 6'h1D, 16'h0055, 1'b1);
    chk("refused", refused, 1'b1);
    bus(1'b0, 6'h1D, 16'h0000, 1'b0);
    chk("locked reg", rdata, 16'h0000);
    bus(1'b1, 6'h1D, 16'h0055, 1'b0);
    bus(1'b0, 6'h1D, 16'h0000, 1'b0);
    chk("local reg", rdata, 16'h0055);
    $display("test lockout done");
    @(posedge clk_in);
    positive_travel_limit_in <= 1'b1;
    positive_soft_limit_in <= 1'b1;
    mains_loss_warning_flag_in <= 1'b1;
    alarm_sub_in <= 8'hA5;
    travel_stopped_in <= 1'b1;
    cmd_toward_inhibit_in <= 1'b1;
    settle();
    chk("status plain", status_out, {2'h2, 2'h2, 1'h0, 8'h00});
    chk("no cmd err", cmd_error_out, 1'b0);
    bus(1'b1, 6'h17, 16'h038A, 1'b0);
    settle();
    chk("status swap", status_out, {2'h1, 2'h1, 1'h1, 8'hA5});
    chk("cmd err", cmd_error_out, 1'b1);
    bus(1'b1, 6'h17, 16'h03CE, 1'b0);
    settle();
    chk("hw inverted", status_out.hw_limit, 2'h2);
    @(posedge clk_in);
    travel_func_off_in <= 1'b1;
    settle();
    chk("hw forced", status_out.hw_limit, 2'h0);
    $display("test status done");
    @(posedge clk_in);
    link_up_in <= 1'b1;
    external_output_one_in <= 1'b1;
    external_output_two_in <= 1'b1;
    bus(1'b1, 6'h18, 16'h0001, 1'b0);
    bus(1'b1, 6'h1A, 16'h0002, 1'b0);
    bus(1'b1, 6'h1B, 16'h0002, 1'b0);
    bus(1'b1, 6'h1C, 16'h0001, 1'b0);
    bus(1'b1, 6'h17, 16'h0010, 1'b0);
    // warning must wait for exactly the threshold count
    for (i = 0; i < 2; i++) begin
      @(posedge clk_in);
      comm_error_in <= 1'b1;
      refresh_fault_in <= 1'b1;
      @(posedge clk_in);
      comm_error_in <= 1'b0;
      refresh_fault_in <= 1'b0;
      settle();
      chk("cons warn", warn_out.consecutive_error_warning, i == 1);
    end
    chk("total on", warn_out.total_error_warning, 1'b1);
    chk("refresh off", warn_out.refresh_fault_warning, 1'b0);
    chk("led mode2", link_indicator_led_out, 1'b0);
    @(posedge clk_in);
    warn_clear_in <= 1'b1;
    @(posedge clk_in);
    warn_clear_in <= 1'b0;
    settle();
    chk("cleared", warn_out, 3'h0);
    chk("led back", link_indicator_led_out, 1'b1);
    @(posedge clk_in);
    link_up_in <= 1'b0;
    settle();
    chk("out one init", external_output_one_out, 1'b0);
    chk("out two held", external_output_two_out, 1'b1);
    $display("test warnings done");
    bus(1'b1, 6'h22, 16'h0033, 1'b0);
    @(posedge clk_in);
    noncyclic_zero_in <= 1'b1;
    std_cmd_in <= 16'h0005;
    actual_position_in <= 32'h11112222;
    actual_speed_in <= 32'h33334444;
    thrust_value_in <= 32'h55556666;
    stall <= 1'b1;
    // a 16-byte frame, then a 32-byte frame with the first sub slot skipped
    for (i = 0; i < 2; i++) begin
      if (i == 1) bus(1'b1, 6'h16, 16'h0001, 1'b0);
      @(posedge clk_in);
      frame_start_in <= 1'b1;
      @(posedge clk_in);
      frame_start_in <= 1'b0;
      #1 chk("nc start", noncyclic_start_out, i == 0);
      repeat (40) @(posedge clk_in);
    end
    chk("words", host.cnt, 8);
    chk("slot1", host.got[0], {3'h1, 8'h55, 32'h00000000});
    chk("slot2", host.got[1], {3'h2, 8'h00, 32'h33334444});
    chk("slot3", host.got[2], {3'h3, 8'h00, 32'h55556666});
    chk("sub two", host.got[6], {3'h5, 8'h00, 32'h00000000});
    chk("sub three", host.got[7], {3'h6, 8'h33, 32'h00000000});
    $display("test reply done");
    test_done();
  end
endmodule
